// [pkg/fwg_pkg.sv]
package fwg_pkg;

  // Opcodes
  localparam logic [7:0] FWG_OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] FWG_OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] FWG_OP_PROTECT = 8'h36;
  localparam logic [7:0] FWG_OP_UNPROTECT = 8'h39;

  // Framing
  localparam int FWG_BITS_PER_BYTE = 8;
  localparam int FWG_ADDR_BYTES = 3;
  localparam int FWG_ADDR_W = 24;

  // Sector geometry: 64-Kbyte sectors start at address bit 16
  localparam int FWG_SECTOR_LSB = 16;
  localparam int FWG_NUM_SECTORS = 64;

  // Reset values
  localparam logic FWG_WEL_RST = 1'b0;
  localparam logic FWG_PROT_RST = 1'b1;
  localparam logic [2:0] FWG_PIN_RST = 3'h4;

  // Timing of the serial clock in the bench, ns, and of the core clock
  localparam int FWG_CLK_PERIOD_NS = 50;
  localparam int FWG_SCK_PERIOD_NS = 400;
  localparam int FWG_SCK_CYCLES = FWG_SCK_PERIOD_NS / FWG_CLK_PERIOD_NS;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } fwg_pin_t;

  typedef struct packed {
    logic valid;
    logic to_array;
    logic [FWG_ADDR_W-1:0] addr;
  } fwg_req_t;

endpackage

// [hdl/fwg_sync.sv]
`timescale 1ns/1ps
module fwg_sync
  import fwg_pkg::*;
#(
  parameter int W = 3,
  parameter logic [W-1:0] RST = '0
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_q;
  logic [W-1:0] q_d;

  // Refuse a width the synchroniser cannot carry
  if (W < 1)
  begin
    $error("fwg_sync width must be at least one");
  end

  // A bit changes only once the second and third stages agree
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      q_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : q_q[i];
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      q_q <= RST;
    end
    else if (clk_en)
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q <= q_d;
    end
  end

  assign q = q_q;

endmodule

// [hdl/fwg_guard.sv]
`timescale 1ns/1ps
// Function
// - Guarded commands need latch set beforehand
// - Opcode 06h sets latch at frame end
// - Short or misaligned latch commands change nothing
// - Opcode 04h clears latch at frame end
// - One guard flag per 64-Kbyte sector
// - All flags start guarded after reset
// - Block program/erase to guarded sectors
// - Opcode 36h plus three address bytes
// - Valid protect sets flag, clears latch
// - Short protect aborts, clears latch only
// - Lock bit: protect ignored, latch cleared
// - Opcode 39h plus three address bytes
// - Valid unprotect clears flag and latch
// - Short unprotect aborts, clears latch only
// - Lock bit: unprotect ignored, latch cleared
// - Suspend: sector commands ignored entirely
module fwg_guard
  import fwg_pkg::*;
#(
  parameter int NUM_SECTORS = FWG_NUM_SECTORS,
  parameter int SECTOR_LSB = FWG_SECTOR_LSB
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  input wire fwg_pin_t pins,
  input wire logic protection_lock_bit,
  input wire logic suspended,
  input wire fwg_req_t req,
  output logic write_enable_latch_q,
  output logic [NUM_SECTORS-1:0] sector_prot_q,
  output logic grant_q,
  output logic deny_q
);

  localparam int SECW = (NUM_SECTORS > 1) ? $clog2(NUM_SECTORS) : 1;

  // Refuse geometries the flag array cannot index
  if (NUM_SECTORS < 2 || (1 << SECW) != NUM_SECTORS)
  begin
    $error("NUM_SECTORS must be a power of two, at least two");
  end
  if (SECTOR_LSB + SECW > FWG_ADDR_W)
  begin
    $error("Sector index does not fit in the byte address");
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPCODE,
    ST_ADDR,
    ST_TRAIL,
    ST_IGNORE
  } fwg_state_t;

  function automatic logic [SECW-1:0] sec_idx(input logic [FWG_ADDR_W-1:0] a);
    sec_idx = a[SECTOR_LSB +: SECW];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  fwg_pin_t pin_s;
  logic [2:0] pin_raw;

  fwg_sync #(
    .W(3),
    .RST(FWG_PIN_RST)
  ) u_sync (
    .clock(clock),
    .reset(reset),
    .clk_en(clk_en),
    .d(pins),
    .q(pin_raw)
  );

  assign pin_s = fwg_pin_t'(pin_raw);

  logic sck_prev_q;
  logic cs_prev_q;
  logic sck_rise;
  logic cs_fall;
  logic cs_rise;

  assign sck_rise = pin_s.sck & ~sck_prev_q;
  assign cs_fall = cs_prev_q & ~pin_s.cs_n;
  assign cs_rise = ~cs_prev_q & pin_s.cs_n;

  ////////////////////////////////////////////////////////////////////////////
  // Command framing

  fwg_state_t st_q;
  fwg_state_t st_d;
  logic [2:0] bit_q;
  logic [2:0] bit_d;
  logic [1:0] byte_q;
  logic [1:0] byte_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] opcode_q;
  logic [7:0] opcode_d;
  logic [FWG_ADDR_W-1:0] addr_q;
  logic [FWG_ADDR_W-1:0] addr_d;
  logic wel_arr_q;
  logic wel_arr_d;
  logic wel_d;
  logic [NUM_SECTORS-1:0] prot_d;
  logic [7:0] byte_in;
  logic is_sector_op;
  logic aligned;

  assign byte_in = {shift_q[6:0], pin_s.si};
  assign is_sector_op = (opcode_q == FWG_OP_PROTECT) || (opcode_q == FWG_OP_UNPROTECT);
  assign aligned = (bit_q == 3'h0);

  always_comb
  begin
    st_d = st_q;
    bit_d = bit_q;
    byte_d = byte_q;
    shift_d = shift_q;
    opcode_d = opcode_q;
    addr_d = addr_q;
    wel_arr_d = wel_arr_q;
    wel_d = write_enable_latch_q;
    prot_d = sector_prot_q;
    if (cs_rise)
    begin
      st_d = ST_IDLE;
      unique case (st_q)
        ST_TRAIL:
        begin
          if (opcode_q == FWG_OP_WR_ENABLE && aligned)
            wel_d = 1'b1;
          else if (opcode_q == FWG_OP_WR_DISABLE && aligned)
            wel_d = 1'b0;
          else if (is_sector_op)
          begin
            wel_d = 1'b0;
            if (aligned && !protection_lock_bit && wel_arr_q)
              prot_d[sec_idx(addr_q)] = (opcode_q == FWG_OP_PROTECT);
          end
        end
        ST_ADDR:
        begin
          wel_d = 1'b0;
        end
        ST_IDLE, ST_OPCODE, ST_IGNORE:
        begin
          wel_d = write_enable_latch_q;
        end
      endcase
    end
    else if (cs_fall)
    begin
      st_d = ST_OPCODE;
      bit_d = 3'h0;
      byte_d = 2'h0;
    end
    else if (!pin_s.cs_n && sck_rise && st_q != ST_IDLE)
    begin
      shift_d = byte_in;
      bit_d = bit_q + 3'h1;
      if (bit_q == 3'(FWG_BITS_PER_BYTE - 1))
      begin
        unique case (st_q)
          ST_OPCODE:
          begin
            opcode_d = byte_in;
            wel_arr_d = write_enable_latch_q;
            if ((byte_in == FWG_OP_PROTECT || byte_in == FWG_OP_UNPROTECT) && suspended)
              st_d = ST_IGNORE;
            else if (byte_in == FWG_OP_PROTECT || byte_in == FWG_OP_UNPROTECT)
              st_d = ST_ADDR;
            else
              st_d = ST_TRAIL;
          end
          ST_ADDR:
          begin
            addr_d = {addr_q[FWG_ADDR_W-9:0], byte_in};
            byte_d = byte_q + 2'h1;
            if (byte_q == 2'(FWG_ADDR_BYTES - 1))
              st_d = ST_TRAIL;
          end
          ST_IDLE, ST_TRAIL, ST_IGNORE:
          begin
            st_d = st_q;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      st_q <= ST_IDLE;
      bit_q <= 3'h0;
      byte_q <= 2'h0;
      shift_q <= 8'h00;
      opcode_q <= 8'h00;
      addr_q <= 24'h000000;
      wel_arr_q <= 1'b0;
      write_enable_latch_q <= FWG_WEL_RST;
      sector_prot_q <= {NUM_SECTORS{FWG_PROT_RST}};
    end
    else if (clk_en)
    begin
      sck_prev_q <= pin_s.sck;
      cs_prev_q <= pin_s.cs_n;
      st_q <= st_d;
      bit_q <= bit_d;
      byte_q <= byte_d;
      shift_q <= shift_d;
      opcode_q <= opcode_d;
      addr_q <= addr_d;
      wel_arr_q <= wel_arr_d;
      write_enable_latch_q <= wel_d;
      sector_prot_q <= prot_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program, erase and other latch-guarded requests

  logic grant_d;
  logic deny_d;
  logic req_ok;

  // Array writes also need the target sector unguarded
  assign req_ok = write_enable_latch_q
                  && (!req.to_array || !sector_prot_q[sec_idx(req.addr)]);

  always_comb
  begin
    grant_d = req.valid && req_ok;
    deny_d = req.valid && !req_ok;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      grant_q <= 1'b0;
      deny_q <= 1'b0;
    end
    else if (clk_en)
    begin
      grant_q <= grant_d;
      deny_q <= deny_d;
    end
  end

endmodule

// [hdl/fwg_guard_dummy_none.sv]
`timescale 1ns/1ps

// [verif/fwg_host.sv]
`timescale 1ns/1ps
module fwg_host
  import fwg_pkg::*;
(
  output fwg_pin_t pins
);
  initial pins = FWG_PIN_RST;
  // Shifts the top n bits of v; sck rests low, si flips once deselected
  task automatic frame(input logic [47:0] v, input int n);
    pins.cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      pins.si = v[47-i];
      #200 pins.sck = 1'b1;
      #200 pins.sck = 1'b0;
    end
    pins.cs_n = 1'b1;
    pins.si = ~pins.si;
    #1000;
  endtask
endmodule

// [verif/fwg_guard_properties.sv]
`timescale 1ns/1ps
module fwg_guard_properties
  import fwg_pkg::*;
#(
  parameter int NUM_SECTORS = FWG_NUM_SECTORS,
  parameter int SECTOR_LSB = FWG_SECTOR_LSB
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  input wire fwg_pin_t pins,
  input wire logic protection_lock_bit,
  input wire logic suspended,
  input wire fwg_req_t req,
  input wire logic write_enable_latch_q,
  input wire logic [NUM_SECTORS-1:0] sector_prot_q,
  input wire logic grant_q,
  input wire logic deny_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic ok;
  assign ok = write_enable_latch_q &&
    !(req.to_array && sector_prot_q[req.addr[SECTOR_LSB +: $clog2(NUM_SECTORS)]]);
  sequence s_req;
    req.valid && clk_en;
  endsequence
  sequence s_moved;
    !$past(reset) && $changed(sector_prot_q);
  endsequence
  a_reset_guarded: assert property (
    $fell(reset) |-> &sector_prot_q && !write_enable_latch_q) else $error("bad reset");
  a_deny_refused: assert property (
    s_req ##0 !ok |=> deny_q && !grant_q) else $error("no deny");
  a_grant_allowed: assert property (
    s_req ##0 ok |=> grant_q && !deny_q) else $error("no grant");
  a_answer_cause: assert property (
    $past(clk_en) && (grant_q || deny_q) |-> $past(req.valid)) else $error("stray answer");
  a_one_sector: assert property (
    s_moved |-> $onehot(sector_prot_q ^ $past(sector_prot_q))) else $error("many flags");
  a_flag_clears_latch: assert property (
    s_moved |-> $past(write_enable_latch_q) && !write_enable_latch_q) else $error("latch");
  a_latch_frame_end: assert property (
    !$past(reset) && $changed(write_enable_latch_q) |-> pins.cs_n && $past(pins.cs_n, 3))
    else $error("latch mid frame");
  a_lock_freezes: assert property (
    $past(protection_lock_bit) && !$past(reset) |-> $stable(sector_prot_q))
    else $error("locked");
endmodule

bind fwg_guard fwg_guard_properties #(.NUM_SECTORS(NUM_SECTORS), .SECTOR_LSB(SECTOR_LSB))
  fwg_guard_properties_i (.clock(clock), .reset(reset), .clk_en(clk_en), .pins(pins),
  .protection_lock_bit(protection_lock_bit), .suspended(suspended), .req(req),
  .write_enable_latch_q(write_enable_latch_q), .sector_prot_q(sector_prot_q),
  .grant_q(grant_q), .deny_q(deny_q));

// [verif/tb.sv]
`timescale 1ns/1ps
module tb
  import fwg_pkg::*;
;
  typedef struct packed {
    logic [7:0] op;
    logic [23:0] a;
    logic [7:0] n;
    logic [3:0] k;
  } fwg_step_t;
  // k is {lock, suspend, latch, flag}; op 00 is a request with k[2] to_array, k[1] grant
  fwg_step_t steps [26] = '{
    44'h00_000000_00_0, 44'h06_000000_08_3,
    44'h04_000000_0c_3, 44'h04_000000_10_1,
    44'h39_05abcd_20_1, 44'h06_000000_08_3,
    44'h39_05abcd_20_0, 44'h00_050000_00_4,
    44'h06_000000_08_3, 44'h00_050000_00_6,
    44'h00_060000_00_4, 44'h36_051234_28_1,
    44'h06_000000_08_3, 44'h39_03ffff_20_0,
    44'h06_000000_08_3, 44'h36_030000_14_0,
    44'h06_000000_08_3, 44'h39_070000_1f_1,
    44'h06_000000_08_3, 44'h39_070000_24_1,
    44'h06_000000_08_b, 44'h39_090000_20_9,
    44'h06_000000_08_b, 44'h36_030000_20_8,
    44'h06_000000_08_7, 44'h39_090000_20_7
  };
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic protection_lock_bit = 1'b0;
  logic suspended = 1'b0;
  fwg_req_t req = '0;
  fwg_pin_t pins;
  logic write_enable_latch_q, grant_q, deny_q;
  logic [FWG_NUM_SECTORS-1:0] sector_prot_q;
  logic [FWG_NUM_SECTORS-1:0] model = '1;
  int err_total = 0;
  int checks = 0;

  fwg_guard fwg_guard_i (.clock, .reset, .clk_en, .pins, .protection_lock_bit, .suspended,
    .req, .write_enable_latch_q, .sector_prot_q, .grant_q, .deny_q);
  fwg_host fwg_host_i (.pins);

  initial forever #25 clock = ~clock;

  task automatic chk(input logic ok);
    checks++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: value mismatch", $time);
    end
  endtask
  task automatic st(input logic w);
    chk(write_enable_latch_q === w && sector_prot_q === model);
  endtask
  task automatic give_verdict;
    $display("checks %0d, errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    fwg_step_t s;
    repeat (3) @(posedge clock);
    #1 reset = 1'b0;
    st(1'b0);
    foreach (steps[i])
    begin
      s = steps[i];
      if (s.op == 8'h00)
      begin
        req = '{1'b1, s.k[2], s.a};
        @(posedge clock);
        #1 req.valid = 1'b0;
        chk(grant_q === s.k[1] && deny_q === !s.k[1]);
        // Let an edge pass before the next request raises valid again
        @(posedge clock);
        #1;
      end
      else
      begin
        {protection_lock_bit, suspended} = s.k[3:2];
        fwg_host_i.frame({s.op, s.a, 16'h5a5a}, s.n);
        model[s.a[FWG_SECTOR_LSB +: 6]] = s.k[0];
        st(s.k[1]);
      end
    end
    {protection_lock_bit, suspended} = 2'h0;
    // A request held while the clock enable is low is taken only once it returns
    clk_en = 1'b0;
    req = '{1'b1, 1'b0, 24'h000000};
    @(posedge clock);
    #1 chk(grant_q === 1'b0 && deny_q === 1'b0);
    clk_en = 1'b1;
    @(posedge clock);
    #1 req.valid = 1'b0;
    chk(grant_q === 1'b1 && deny_q === 1'b0);
    reset = 1'b1;
    repeat (3) @(posedge clock);
    #1 reset = 1'b0;
    model = '1;
    st(1'b0);
    give_verdict();
  end
endmodule
